// file: rtl/fnrc_consts.svh
// Constants of the field node reset control: timing, offsets, fields.
// Assumes a 100 MHz system clock; included by bare name.
// Notes on behaviour
// - Every reset loads data and parameter output registers with 4'hf.
// - During every reset the data and parameter output drivers float.
// - Non power-on resets pulse data and parameter strobes together.
// - Every reset sets the exchange block; blocked data port stays inactive.
// - Command or pin reset initialisation finishes within 2 ms.
// - Power-on initialisation finishes within 30 ms, 1000 ms with big load.
// - Supply rise or collapse gives a 4 to 6 us power-on pulse, then init.
// - Reset on reset commands, enabled watchdog expiry, illegal state.
// - Addressing channel plus AC current mode: reset commands take alternate path.
// - Pin low for 35 us or less never starts an external reset.
// - Pin reset fires when 44 us low timer expires; init follows at once.
// - Slave mode: pin still low after reset plus init flags serious fault.
`ifndef FNRC_CONSTS_SVH
`define FNRC_CONSTS_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define FNRC_CLK_MHZ       100
`define FNRC_T_NORESET_US  35
`define FNRC_T_RESET_US    44
`define FNRC_T_INIT_MS     2
`define FNRC_T_INIT2_MS    30
`define FNRC_T_INIT3_MS    1000
`define FNRC_T_POR_MIN_US  4
`define FNRC_T_POR_MAX_US  6
`define FNRC_NORESET_CYC   (`FNRC_T_NORESET_US * `FNRC_CLK_MHZ)
`define FNRC_RESET_CYC     (`FNRC_T_RESET_US * `FNRC_CLK_MHZ)
`define FNRC_INIT_CYC      (`FNRC_T_INIT_MS * 1000 * `FNRC_CLK_MHZ)
`define FNRC_INIT2_CYC     (`FNRC_T_INIT2_MS * 1000 * `FNRC_CLK_MHZ)
`define FNRC_INIT3_CYC     (`FNRC_T_INIT3_MS * 1000 * `FNRC_CLK_MHZ)
`define FNRC_POR_MIN_CYC   (`FNRC_T_POR_MIN_US * `FNRC_CLK_MHZ)
`define FNRC_POR_MAX_CYC   (`FNRC_T_POR_MAX_US * `FNRC_CLK_MHZ)

// ------------------------------------------------------------
// Registers
// ------------------------------------------------------------
`define FNRC_OFS_CTRL      4'h0
`define FNRC_OFS_DATA      4'h4
`define FNRC_OFS_PARAM     4'h8
`define FNRC_OFS_STATUS    4'hc
`define FNRC_CTRL_WDOG_EN  0
`define FNRC_CTRL_SLAVE    1
`define FNRC_ST_BLOCK      0
`define FNRC_ST_BUSY       1
`define FNRC_ST_FAULT      2
`define FNRC_ST_POR_INIT   3
`define FNRC_ST_CAUSE      4
`define FNRC_CTRL_RST      8'h02
`define FNRC_OUT_RST       4'hf

`endif

// file: rtl/fnrc_pkg.sv
// Types of the field node reset control.
// Constants live in fnrc_consts.svh.
package fnrc_pkg;

  // ------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {PH_POR, PH_RESET, PH_INIT, PH_RUN} fnrc_phase_t;
  typedef enum logic [2:0] {CS_NONE, CS_POR, CS_CMD, CS_WDOG, CS_ILLEGAL, CS_EXT} fnrc_cause_t;

  // ------------------------------------------------------------
  // State records
  // ------------------------------------------------------------
  typedef struct packed {
    fnrc_phase_t phase;
    fnrc_cause_t cause;
    logic        por_init;
    logic [31:0] cnt;
    logic [7:0]  ctrl;
    logic [3:0]  data_out;
    logic [3:0]  param_out;
    logic        data_oe_b;
    logic        param_oe_b;
    logic        data_stb;
    logic        param_stb;
    logic        xblock;
    logic        busy;
    logic        fault;
    logic        alt_cmd;
    logic [7:0]  rd_data;
  } fnrc_top_st_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        low;
    logic        fired;
    logic        evt;
  } fnrc_pin_st_t;

  typedef struct packed {
    logic        por;
    logic [31:0] cnt;
  } fnrc_por_st_t;

  // Register address match, used by the write decode; reads decode with a case
  function automatic logic fnrc_hit(input logic [3:0] addr, input logic [3:0] ofs);
    return addr == ofs;
  endfunction : fnrc_hit

endpackage : fnrc_pkg

// file: rtl/fnrc_pin_timer.sv
// Low-time timer of the strobe/reset pin.
// Assumes the pin level is already synchronous to i_clk_sys.
`timescale 1ns/1ps
`include "fnrc_consts.svh"
module fnrc_pin_timer #(
  parameter int unsigned P_RESET_CYC = `FNRC_RESET_CYC
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // Pin level
  input  wire logic i_pin,
  // Results
  output logic      o_reset_evt,
  output logic      o_pin_low
);
  // No-reset window scaled with the reset count, so shortened counts keep the ratio
  localparam int unsigned L_NORESET_CYC = (P_RESET_CYC * `FNRC_T_NORESET_US) / `FNRC_T_RESET_US;

  fnrc_pkg::fnrc_pin_st_t st;
  fnrc_pkg::fnrc_pin_st_t next_st;

  if (P_RESET_CYC < 2) begin : g_chk
    $error("P_RESET_CYC too small");
  end

  // One event per low period; the timer restarts only after the pin is high
  always_comb begin
    next_st     = st;
    next_st.evt = 1'b0;
    next_st.low = !i_pin;
    if (i_pin) begin
      next_st.cnt   = 32'h0;
      next_st.fired = 1'b0;
    end else if (!st.fired) begin
      if (st.cnt == 32'(P_RESET_CYC - 1)) begin
        next_st.evt   = 1'b1;
        next_st.fired = 1'b1;
      end
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_reset_evt = st.evt;
  assign o_pin_low   = st.low;

  a_evt_full_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_reset_evt |-> st.cnt == 32'(P_RESET_CYC))
    else $error("pin reset event without full low time");
  a_short_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (st.cnt <= 32'(L_NORESET_CYC)) |-> !o_reset_evt)
    else $error("pin reset after short low time");

endmodule : fnrc_pin_timer

// file: rtl/fnrc_por_gen.sv
// Power-on pulse from the logic supply rail good level.
// Assumes i_supply_ok is synchronous; low means rail collapsed.
`timescale 1ns/1ps
`include "fnrc_consts.svh"
module fnrc_por_gen #(
  parameter int unsigned P_POR_CYC = `FNRC_POR_MIN_CYC
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // Logic supply rail good
  input  wire logic i_supply_ok,
  // Power-on reset pulse
  output logic      o_por
);
  fnrc_pkg::fnrc_por_st_t st;
  fnrc_pkg::fnrc_por_st_t next_st;
  logic [31:0]            ok_run;

  if (P_POR_CYC < 1) begin : g_chk
    $error("P_POR_CYC must be at least one");
  end

  // Held while the rail is down, then stretched a fixed time after it rises
  always_comb begin
    next_st = st;
    if (!i_supply_ok) begin
      next_st.por = 1'b1;
      next_st.cnt = 32'h0;
    end else if (st.por) begin
      if (st.cnt == 32'(P_POR_CYC - 1)) begin
        next_st.por = 1'b0;
      end
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  // State register; reset acts as a rail rise
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '{por: 1'b1, cnt: 32'h0};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_por = st.por;

  // Helper: cycles the pulse stood with the rail good
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ok_run <= 32'h0;
    end else if (i_ce) begin
      ok_run <= (o_por && i_supply_ok) ? ok_run + 32'h1 : 32'h0;
    end
  end

  a_por_width: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $fell(o_por) |-> ($past(ok_run) + 32'h1 >= 32'(`FNRC_POR_MIN_CYC)
                      && $past(ok_run) + 32'h1 <= 32'(`FNRC_POR_MAX_CYC)))
    else $error("power-on pulse width out of range");

endmodule : fnrc_por_gen

// file: rtl/fnrc_top.sv
// Field node reset control: merges reset sources, restores the output
// ports, runs initialisation and holds the exchange block.
// Assumes synchronous inputs and a master that obeys the bus protocol.
`timescale 1ns/1ps
`include "fnrc_consts.svh"
module fnrc_top #(
  parameter int unsigned P_INIT_CYC     = `FNRC_INIT_CYC,
  parameter int unsigned P_INIT_POR_CYC = `FNRC_INIT2_CYC,
  parameter int unsigned P_RESET_CYC    = `FNRC_RESET_CYC
) (
  // Clock, reset, enable
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_ce,
  // Supply and reset sources
  input  wire logic       i_supply_ok,
  input  wire logic       i_cmd_reset_slave,
  input  wire logic       i_cmd_bcast_reset,
  input  wire logic       i_wdog_expired,
  input  wire logic       i_fsm_illegal,
  input  wire logic       i_strobe_pin,
  // Channel mode
  input  wire logic       i_addr_chan_active,
  input  wire logic       i_ac_current_mode,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rd_data,
  // Data port
  output logic      [3:0] o_data_out,
  output logic            o_data_oe_b,
  output logic            o_data_strobe,
  // Parameter port
  output logic      [3:0] o_param_out,
  output logic            o_param_oe_b,
  output logic            o_param_strobe,
  // Status
  output logic            o_xchg_block,
  output logic            o_init_busy,
  output logic            o_serious_fault,
  output logic            o_alt_reset_cmd
);

  // ------------------------------------------------------------
  // Checks and constants
  // ------------------------------------------------------------
  if (P_INIT_CYC < 1 || P_INIT_POR_CYC < 1) begin : g_chk_init
    $error("initialisation counts must be at least one");
  end
  if (P_INIT_CYC > `FNRC_INIT_CYC || P_INIT_POR_CYC > `FNRC_INIT3_CYC) begin : g_chk_max
    $error("initialisation counts exceed the allowed time");
  end

  localparam fnrc_pkg::fnrc_top_st_t ST_RST = '{
    phase:      fnrc_pkg::PH_POR,
    cause:      fnrc_pkg::CS_POR,
    por_init:   1'b1,
    cnt:        32'h0,
    ctrl:       `FNRC_CTRL_RST,
    data_out:   `FNRC_OUT_RST,
    param_out:  `FNRC_OUT_RST,
    data_oe_b:  1'b1,
    param_oe_b: 1'b1,
    data_stb:   1'b0,
    param_stb:  1'b0,
    xblock:     1'b1,
    busy:       1'b1,
    fault:      1'b0,
    alt_cmd:    1'b0,
    rd_data:    8'h00
  };

  fnrc_pkg::fnrc_top_st_t st;
  fnrc_pkg::fnrc_top_st_t next_st;
  logic                   por_busy;
  logic                   pin_evt;
  logic                   pin_low;
  logic                   cmd_any;
  logic                   alt_path;
  logic                   wdog_hit;
  logic                   ev_any;
  logic [31:0]            init_last;

  // ------------------------------------------------------------
  // Reset source helpers
  // ------------------------------------------------------------
  fnrc_por_gen u_por (
    .i_clk_sys   (i_clk_sys),
    .i_rst_b     (i_rst_b),
    .i_ce        (i_ce),
    .i_supply_ok (i_supply_ok),
    .o_por       (por_busy)
  );

  fnrc_pin_timer #(
    .P_RESET_CYC (P_RESET_CYC)
  ) u_pin (
    .i_clk_sys   (i_clk_sys),
    .i_rst_b     (i_rst_b),
    .i_ce        (i_ce),
    .i_pin       (i_strobe_pin),
    .o_reset_evt (pin_evt),
    .o_pin_low   (pin_low)
  );

  // Source qualification
  assign cmd_any   = i_cmd_reset_slave || i_cmd_bcast_reset;
  assign alt_path  = i_addr_chan_active && i_ac_current_mode;
  assign wdog_hit  = i_wdog_expired && st.ctrl[`FNRC_CTRL_WDOG_EN];
  assign ev_any    = (cmd_any && !alt_path) || wdog_hit || i_fsm_illegal || pin_evt;
  assign init_last = st.por_init ? 32'(P_INIT_POR_CYC - 1) : 32'(P_INIT_CYC - 1);

  // ------------------------------------------------------------
  // Reset action
  // ------------------------------------------------------------
  // Shared by power-on, merged sources and the illegal phase branch
  function automatic fnrc_pkg::fnrc_top_st_t apply_reset(
    input fnrc_pkg::fnrc_top_st_t s,
    input fnrc_pkg::fnrc_cause_t  c,
    input logic                   por
  );
    fnrc_pkg::fnrc_top_st_t r;
    r            = s;
    r.phase      = por ? fnrc_pkg::PH_POR : fnrc_pkg::PH_RESET;
    r.cause      = c;
    r.por_init   = por;
    r.cnt        = 32'h0;
    r.data_out   = `FNRC_OUT_RST;
    r.param_out  = `FNRC_OUT_RST;
    r.data_oe_b  = 1'b1;
    r.param_oe_b = 1'b1;
    r.data_stb   = !por;
    r.param_stb  = !por;
    r.xblock     = 1'b1;
    r.busy       = 1'b1;
    return r;
  endfunction : apply_reset

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st           = st;
    next_st.data_stb  = 1'b0;
    next_st.param_stb = 1'b0;
    next_st.alt_cmd   = 1'b0;
    next_st.rd_data   = 8'h00;
    // Read data answer the cycle after the strobe; unmapped reads zero
    if (i_rd) begin
      case (i_addr)
        `FNRC_OFS_CTRL:   next_st.rd_data = st.ctrl;
        `FNRC_OFS_DATA:   next_st.rd_data = {4'h0, st.data_out};
        `FNRC_OFS_PARAM:  next_st.rd_data = {4'h0, st.param_out};
        `FNRC_OFS_STATUS: next_st.rd_data = {1'b0, st.cause, st.por_init, st.fault, st.busy, st.xblock};
        default:          next_st.rd_data = 8'h00;
      endcase
    end
    // Control stays writable in every phase
    if (i_wr && fnrc_pkg::fnrc_hit(i_addr, `FNRC_OFS_CTRL)) begin
      next_st.ctrl = i_wr_data;
    end
    case (st.phase)
      fnrc_pkg::PH_POR: begin
        if (!por_busy) begin
          next_st.phase = fnrc_pkg::PH_INIT;
          next_st.cnt   = 32'h0;
        end
      end
      fnrc_pkg::PH_RESET: begin
        // Single cycle of merged reset, then init on the next edge
        next_st.phase = fnrc_pkg::PH_INIT;
        next_st.cnt   = 32'h0;
      end
      fnrc_pkg::PH_INIT: begin
        if (st.cnt == init_last) begin
          next_st.phase = fnrc_pkg::PH_RUN;
          next_st.busy  = 1'b0;
        end else begin
          next_st.cnt = st.cnt + 32'h1;
        end
      end
      fnrc_pkg::PH_RUN: begin
        // Parameter write lifts the block and enables both drivers
        if (i_wr && fnrc_pkg::fnrc_hit(i_addr, `FNRC_OFS_PARAM)) begin
          next_st.param_out  = i_wr_data[3:0];
          next_st.param_oe_b = 1'b0;
          next_st.param_stb  = 1'b1;
          next_st.xblock     = 1'b0;
          next_st.data_oe_b  = 1'b0;
        end
        // Data writes while blocked are dropped without trace
        if (i_wr && fnrc_pkg::fnrc_hit(i_addr, `FNRC_OFS_DATA) && !st.xblock) begin
          next_st.data_out = i_wr_data[3:0];
          next_st.data_stb = 1'b1;
        end
      end
      default: begin
        next_st = apply_reset(next_st, fnrc_pkg::CS_ILLEGAL, 1'b0);
      end
    endcase
    // Fault follows the pin: clear on high, set placed last so it wins
    if (!pin_low) begin
      next_st.fault = 1'b0;
    end
    if (st.phase == fnrc_pkg::PH_RUN && st.cause == fnrc_pkg::CS_EXT && pin_low
        && st.ctrl[`FNRC_CTRL_SLAVE]) begin
      next_st.fault = 1'b1;
    end
    // Alternate command handling bypasses the reset
    if (cmd_any && alt_path) begin
      next_st.alt_cmd = 1'b1;
    end
    // Power-on outranks every other source
    if (por_busy) begin
      next_st = apply_reset(next_st, fnrc_pkg::CS_POR, 1'b1);
    end else if (ev_any) begin
      if (pin_evt) begin
        next_st = apply_reset(next_st, fnrc_pkg::CS_EXT, 1'b0);
      end else if (i_fsm_illegal) begin
        next_st = apply_reset(next_st, fnrc_pkg::CS_ILLEGAL, 1'b0);
      end else if (wdog_hit) begin
        next_st = apply_reset(next_st, fnrc_pkg::CS_WDOG, 1'b0);
      end else begin
        next_st = apply_reset(next_st, fnrc_pkg::CS_CMD, 1'b0);
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Frozen while the enable is low
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= ST_RST;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign o_rd_data       = st.rd_data;
  assign o_data_out      = st.data_out;
  assign o_data_oe_b     = st.data_oe_b;
  assign o_data_strobe   = st.data_stb;
  assign o_param_out     = st.param_out;
  assign o_param_oe_b    = st.param_oe_b;
  assign o_param_strobe  = st.param_stb;
  assign o_xchg_block    = st.xblock;
  assign o_init_busy     = st.busy;
  assign o_serious_fault = st.fault;
  assign o_alt_reset_cmd = st.alt_cmd;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_quiet_reset;
    st.phase == fnrc_pkg::PH_RESET && i_ce && !ev_any && !por_busy;
  endsequence
  sequence s_init_start;
    st.phase == fnrc_pkg::PH_INIT && st.cnt == 32'h0 && o_init_busy;
  endsequence

  a_reset_ones: assert property (
    (st.phase != fnrc_pkg::PH_RUN && st.phase != fnrc_pkg::PH_INIT) |-> (o_data_out == 4'hf && o_param_out == 4'hf))
    else $error("outputs not all ones in reset");
  a_reset_float: assert property (
    (st.phase == fnrc_pkg::PH_RESET || st.phase == fnrc_pkg::PH_POR) |-> (o_data_oe_b && o_param_oe_b))
    else $error("drivers active during reset");
  a_strobe_pair: assert property (
    st.phase == fnrc_pkg::PH_RESET |-> (o_data_strobe && o_param_strobe))
    else $error("reset strobes missing or split");
  a_por_silent: assert property (
    st.phase == fnrc_pkg::PH_POR |-> (!o_data_strobe && !o_param_strobe))
    else $error("strobe at power-on reset");
  a_block_data: assert property (
    (i_ce && o_xchg_block && i_wr && i_addr == `FNRC_OFS_DATA) |=> !o_data_strobe || st.phase == fnrc_pkg::PH_RESET)
    else $error("data activity while blocked");
  a_init_short: assert property (
    (st.phase == fnrc_pkg::PH_INIT && !st.por_init) |-> st.cnt < 32'(P_INIT_CYC))
    else $error("initialisation too long");
  a_init_por: assert property (
    (st.phase == fnrc_pkg::PH_INIT && st.por_init) |-> st.cnt < 32'(P_INIT_POR_CYC))
    else $error("power-on initialisation too long");
  a_cmd_reset: assert property (
    (i_ce && cmd_any && !alt_path && !por_busy) |=> st.phase == fnrc_pkg::PH_RESET)
    else $error("reset command ignored");
  a_alt_cmd: assert property (
    (i_ce && cmd_any && alt_path && !por_busy && !wdog_hit && !i_fsm_illegal && !pin_evt)
      |=> (o_alt_reset_cmd && st.phase != fnrc_pkg::PH_RESET))
    else $error("alternate command handled as reset");
  a_pin_reset: assert property (
    (i_ce && pin_evt && !por_busy) |=> (st.phase == fnrc_pkg::PH_RESET ##1 st.phase == fnrc_pkg::PH_INIT || !i_ce))
    else $error("pin reset not followed by init");
  a_fault_slave: assert property (
    $rose(o_serious_fault) |-> ($past(st.ctrl[`FNRC_CTRL_SLAVE]) && $past(pin_low)))
    else $error("fault outside slave mode");
  a_reset_release: assert property (
    s_quiet_reset |=> s_init_start)
    else $error("merged reset not released into init");

endmodule : fnrc_top

// file: tb/fnrc_master_model.sv
// Bus master model: reset commands and register accesses toward the node.
// Assumes the bench calls its tasks; every signal changes just after a rising edge.
`timescale 1ns/1ps
module fnrc_master_model (
  // Clock and read data
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rd_data,
  // Commands
  output logic            o_cmd_reset_slave,
  output logic            o_cmd_bcast_reset,
  // Register port
  output logic      [3:0] o_addr,
  output logic      [7:0] o_wr_data,
  output logic            o_wr,
  output logic            o_rd
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Idle bus shows inverted last values, so stale data never looks valid
  initial begin
    {o_cmd_reset_slave, o_cmd_bcast_reset, o_wr, o_rd} = 4'h0;
    o_addr    = 4'h0;
    o_wr_data = 8'h00;
  end

  // One-cycle reset command, slave or broadcast
  task automatic cmd(input logic bcast);
    @(posedge i_clk_sys);
    o_cmd_reset_slave <= ~bcast;
    o_cmd_bcast_reset <= bcast;
    @(posedge i_clk_sys);
    {o_cmd_reset_slave, o_cmd_bcast_reset} <= 2'h0;
  endtask : cmd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr    <= a;
    o_wr_data <= d;
    o_wr      <= 1'b1;
    @(posedge i_clk_sys);
    o_wr      <= 1'b0;
    o_addr    <= ~a;
    o_wr_data <= ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk_sys);
    q = i_rd_data;
  endtask : rd

  // Parameters always go out before the first data exchange
  task automatic exchange(input logic [3:0] p, input logic [3:0] d);
    wr(4'h8, {4'h0, p});
    wr(4'h4, {4'h0, d});
  endtask : exchange
endmodule : fnrc_master_model

// file: tb/fnrc_top_tb.sv
// Self-checking bench of the field node reset control.
// Assumes shortened init and pin counts; the master model owns the register port.
`timescale 1ns/1ps
module fnrc_top_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int unsigned P_INIT = 20;
  localparam int unsigned P_RST  = 10;
  logic       clk, rst_b, supply_ok, wdog, illegal, pin, chan, acm, cmd_rs, cmd_br, wr, rd, ce;
  logic [3:0] addr, dout, pout;
  logic [7:0] wdata, rdata, q;
  logic       doe_b, poe_b, dstb, pstb, blk, busy, fault, alt;
  int         err_total = 0, total_checks = 0, cyc = 0, stb_cnt = 0, n, s0;

  fnrc_master_model u_m (.i_clk_sys(clk), .i_rd_data(rdata), .o_cmd_reset_slave(cmd_rs),
    .o_cmd_bcast_reset(cmd_br), .o_addr(addr), .o_wr_data(wdata), .o_wr(wr), .o_rd(rd));

  fnrc_top #(.P_INIT_CYC(P_INIT), .P_INIT_POR_CYC(30), .P_RESET_CYC(P_RST)) u_dut (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce), .i_supply_ok(supply_ok),
    .i_cmd_reset_slave(cmd_rs), .i_cmd_bcast_reset(cmd_br), .i_wdog_expired(wdog),
    .i_fsm_illegal(illegal), .i_strobe_pin(pin), .i_addr_chan_active(chan),
    .i_ac_current_mode(acm), .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd),
    .o_rd_data(rdata), .o_data_out(dout), .o_data_oe_b(doe_b), .o_data_strobe(dstb),
    .o_param_out(pout), .o_param_oe_b(poe_b), .o_param_strobe(pstb), .o_xchg_block(blk),
    .o_init_busy(busy), .o_serious_fault(fault), .o_alt_reset_cmd(alt));

  // Clock, strobe counter and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (dstb === 1'b1 || pstb === 1'b1) stb_cnt++;
    if (cyc == 6000) begin
      err_total++;
      $display("[ERR] timeout expected 0 seen 1");
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic check_rst(input logic s);
    chk("outputs", {dout, pout}, 8'hff);
    chk("oe_b", {6'h0, doe_b, poe_b}, 8'h03);
    chk("strobes", {6'h0, dstb, pstb}, {6'h0, s, s});
    chk("block_busy", {6'h0, blk, busy}, 8'h03);
  endtask : check_rst

  // Bounded wait for the end of init; n counts busy cycles
  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_idle

  task automatic fire(input int k);
    if (k < 2) u_m.cmd(k[0]);
    else begin
      @(posedge clk);
      if (k == 2) wdog <= 1'b1;
      else illegal <= 1'b1;
      @(posedge clk);
      {wdog, illegal} <= 2'b00;
    end
  endtask : fire

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Power-on after reset release, or a supply collapse; never strobes
  task automatic t_power(input bit collapse);
    if (collapse) begin
      u_m.exchange(4'h3, 4'h6);
      @(posedge clk);
      supply_ok <= 1'b0;
      repeat (5) @(posedge clk);
      supply_ok <= 1'b1;
    end
    s0 = stb_cnt;
    @(negedge clk);
    check_rst(1'b0);
    wait_idle(n);
    chk("por_len", {7'h0, n >= 400 && n <= 440}, 8'h01);
    chk("por_strobes", 8'(stb_cnt - s0), 8'h00);
    $display("done t_power %0d", collapse);
  endtask : t_power

  // Register map, refused data write, then parameter write lifts the block
  task automatic t_regs;
    u_m.rd(4'h0, q);
    chk("ctrl_rst", q, 8'h02);
    u_m.wr(4'h6, 8'hff);
    u_m.rd(4'h2, q);
    chk("unmapped", q, 8'h00);
    u_m.rd(4'h0, q);
    chk("ctrl_kept", q, 8'h02);
    u_m.rd(4'hc, q);
    chk("status", q, 8'h19);
    u_m.wr(4'h4, 8'h03);
    @(negedge clk);
    chk("blocked_data", {dout, 3'h0, doe_b}, 8'hf1);
    u_m.wr(4'h8, 8'h05);
    @(negedge clk);
    chk("param_wr", {pout, 1'b0, blk, poe_b, pstb}, 8'h51);
    u_m.wr(4'h4, 8'h0a);
    @(negedge clk);
    chk("data_wr", {dout, 2'h0, dstb, doe_b}, 8'ha2);
    $display("done t_regs");
  endtask : t_regs

  // Disabled watchdog ignored; each logic source resets and re-inits in time
  task automatic t_sources;
    fire(2);
    @(negedge clk);
    chk("wdog_off", {7'h0, busy}, 8'h00);
    u_m.wr(4'h0, 8'h03);
    for (int k = 0; k < 4; k++) begin
      u_m.exchange(4'h5, 4'h9);
      fire(k);
      @(negedge clk);
      check_rst(1'b1);
      wait_idle(n);
      chk("init_len", {7'h0, n >= P_INIT && n <= P_INIT + 2}, 8'h01);
    end
    $display("done t_sources");
  endtask : t_sources

  // Both commands take the alternate path in addressing channel plus AC mode
  task automatic t_alt;
    u_m.exchange(4'h5, 4'h9);
    @(posedge clk);
    {chan, acm} <= 2'b11;
    for (int b = 0; b < 2; b++) begin
      u_m.cmd(b[0]);
      @(negedge clk);
      chk("alt_cmd", {2'h0, alt, busy, pout}, 8'h25);
    end
    @(posedge clk);
    {chan, acm, ce} <= 3'b000;
    u_m.cmd(1'b0);
    @(negedge clk);
    chk("ce_frozen", {7'h0, busy}, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    $display("done t_alt");
  endtask : t_alt

  // Short pin low ignored; long low resets once, then slave fault until release
  task automatic t_pin;
    @(posedge clk);
    pin <= 1'b0;
    repeat (P_RST - 1) @(posedge clk);
    pin <= 1'b1;
    repeat (4) @(negedge clk);
    chk("short_low", {7'h0, busy}, 8'h00);
    @(posedge clk);
    pin <= 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("pin_fire", {7'h0, n >= P_RST && n <= P_RST + 3}, 8'h01);
    check_rst(1'b1);
    wait_idle(n);
    chk("pin_init", {7'h0, n <= P_INIT + 2}, 8'h01);
    repeat (2) @(negedge clk);
    chk("fault_on", {6'h0, fault, busy}, 8'h02);
    @(posedge clk);
    pin <= 1'b1;
    repeat (3) @(negedge clk);
    chk("fault_off", {7'h0, fault}, 8'h00);
    $display("done t_pin");
  endtask : t_pin

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    {rst_b, wdog, illegal, chan, acm} = 5'h0;
    {supply_ok, pin, ce} = 3'b111;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_power(1'b0);
    t_regs();
    t_sources();
    t_alt();
    t_pin();
    t_power(1'b1);
    tally_and_finish();
  end
endmodule : fnrc_top_tb
